// >>> rtl/dac_rst_pkg.sv
// Shared constants of the supply reset, recall and serial write block.
// Assumes a single 250 MHz core clock; all pins are asynchronous to it.
package dac_rst_pkg;
    // Core clock period in picoseconds
    localparam int CLK_PERIOD_PS = 4000;
    // Reset delay after a rising-supply reset, in nanoseconds
    localparam int RESET_DELAY_NS = 50000;
    localparam int RESET_DELAY_CYC = (RESET_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Power-down select encodings and their output loads
    localparam logic [1:0] PD_NORMAL = 2'h0;
    localparam logic [1:0] PD_LOAD_1K = 2'h1;
    localparam logic [1:0] PD_LOAD_125K = 2'h2;
    localparam logic [1:0] PD_LOAD_640K = 2'h3;

    // Reference source select encodings
    localparam logic [1:0] VREF_SUPPLY = 2'h0;
    localparam logic [1:0] VREF_PIN_UNBUF = 2'h2;
    localparam logic [1:0] VREF_PIN_BUF = 2'h3;
    localparam int VREF_PIN_BIT = 1;

    // Serial framing
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [7:0] GCALL_ADDR = 8'h00;
    localparam logic [7:0] GCALL_RESET_CMD = 8'h06;
    localparam logic [6:0] DEF_DEV_ADDR = 7'h60;
    localparam logic [1:0] IDX_ADDR = 2'h0;
    localparam logic [1:0] IDX_FIRST = 2'h1;
    localparam logic [1:0] IDX_LAST = 2'h2;

    // Write frame layout: first data byte holds power-down and code top nibble
    localparam int FULL_CODE_W = 12;
    localparam int WR_PD_HI = 5;
    localparam int WR_PD_LO = 4;
    localparam int WR_CODE_HI = 3;

    // Pin synchroniser lanes
    localparam int SYNC_SUPPLY = 0;
    localparam int SYNC_SCL = 1;
    localparam int SYNC_SDA = 2;
    localparam int SYNC_LANES = 3;
endpackage

// >>> rtl/dac_supply_reset_and_recall.sv
// Supply reset, nonvolatile recall, brown-out clamp and serial DAC code write.
// Assumes a supply comparator level, scl and sda pins, and nonvolatile copies on ports.
//
// Contract
// - Rising supply recalls stored code
// - Rising supply recalls stored configuration bits
// - Rising supply sets reset status flag
// - Serial port shut until reset delay ends
// - Output follows volatile bits and code only
// - Falling supply forces power-down select eleven
// - Falling supply clears volatile code
// - Falling supply clears reference and gain bits
// - Target only; clock only ever input
// - Sample on rise, drive after fall
// - Data pin open-drain pull-down only
// - Power-down picks one of three loads
// - Supply reference disconnects reference pin
// - Reference pin offers buffered or unbuffered path
// - Gain one or two from multiplier bit
// - Supply reference forces unity gain
// - Code latched at final acknowledge fall
// - General call reset recalls stored settings
`timescale 1ns/1ps
module dac_supply_reset_and_recall #(
    parameter int CODE_W = 12,
    parameter int RESET_DELAY_CYCLES = dac_rst_pkg::RESET_DELAY_CYC,
    parameter logic [6:0] DEV_ADDR = dac_rst_pkg::DEF_DEV_ADDR
)
(
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic supply_ok_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    input wire logic [CODE_W-1:0] nv_code_i,
    input wire logic [1:0] nv_power_down_select_i,
    input wire logic [1:0] nv_reference_source_select_i,
    input wire logic nv_output_multiplier_bit_i,
    input wire logic por_flag_clr_i,
    output logic por_flag_o,
    output logic bus_ready_o,
    output logic [CODE_W-1:0] ladder_code_o,
    output logic [1:0] power_down_select_o,
    output logic [1:0] reference_source_select_o,
    output logic output_multiplier_bit_o,
    output logic amp_enable_o,
    output logic [1:0] pulldown_load_o,
    output logic ref_pin_connect_o,
    output logic ref_buffer_en_o,
    output logic gain_two_o
);
    import dac_rst_pkg::*;

    localparam int TW = $clog2(RESET_DELAY_CYCLES + 1);

    // Refused at elaboration; only the three ladder widths are decoded
    generate
        if (!(CODE_W == 8 || CODE_W == 10 || CODE_W == 12))
        begin : g_bad_width
            $error("CODE_W must be 8, 10 or 12");
        end
        if (RESET_DELAY_CYCLES < 1)
        begin : g_bad_delay
            $error("RESET_DELAY_CYCLES must be at least one");
        end
    endgenerate

    logic [SYNC_LANES-1:0] pins_s;
    logic sup_d_reg;
    logic [CODE_W-1:0] code_reg, code_next;
    logic [1:0] pd_reg, pd_next, vref_reg, vref_next;
    logic gain_reg, gain_next;
    logic por_flag_reg, por_flag_next;
    logic [TW-1:0] timer_reg, timer_next;
    logic bus_ready_reg, bus_ready_next;
    logic [7:0] wr_byte1_reg;
    logic sda_oe_n_reg, sda_low_reg;
    logic amp_en_reg, ref_conn_reg, ref_buf_reg, gain2_reg;
    logic [1:0] load_reg;

    i2c_evt_if evt();

    pin_sync #(
        .W(SYNC_LANES)
    ) u_sync (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .async_i({sda_i, scl_i, supply_ok_i}),
        .sync_o(pins_s)
    );

    i2c_target_rx #(
        .DEV_ADDR(DEV_ADDR)
    ) u_rx (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .scl_i(pins_s[SYNC_SCL]),
        .sda_i(pins_s[SYNC_SDA]),
        .enable_i(bus_ready_reg),
        .evt(evt.rx)
    );

    wire sup_s = pins_s[SYNC_SUPPLY];
    wire por_evt = sup_s & ~sup_d_reg;
    wire bor_evt = ~sup_s & sup_d_reg;
    wire gcall_reload = evt.byte_done && evt.is_gcall && (evt.byte_idx == IDX_FIRST)
        && (evt.byte_data == GCALL_RESET_CMD);
    wire wr_commit = evt.byte_done && !evt.is_gcall && (evt.byte_idx == IDX_LAST);
    wire [FULL_CODE_W-1:0] wr_full = {wr_byte1_reg[WR_CODE_HI:0], evt.byte_data};
    wire [CODE_W-1:0] wr_code = wr_full[FULL_CODE_W-1 -: CODE_W];
    wire [1:0] wr_pd = wr_byte1_reg[WR_PD_HI:WR_PD_LO];
    wire timer_done = (timer_reg == '0);
    wire pin_ref = vref_reg[VREF_PIN_BIT];
    wire powered = (pd_reg == PD_NORMAL);

    // Brown-out outranks recall, recall outranks a serial write
    always_comb
    begin
        code_next = code_reg;
        pd_next = pd_reg;
        vref_next = vref_reg;
        gain_next = gain_reg;
        timer_next = timer_done ? timer_reg : timer_reg - 1'b1;
        bus_ready_next = bus_ready_reg;
        if (bor_evt)
        begin
            pd_next = PD_LOAD_640K;
            code_next = '0;
            vref_next = VREF_SUPPLY;
            gain_next = 1'b0;
            bus_ready_next = 1'b0;
            timer_next = '0;
        end
        else if (por_evt || gcall_reload)
        begin
            code_next = nv_code_i;
            pd_next = nv_power_down_select_i;
            vref_next = nv_reference_source_select_i;
            gain_next = nv_output_multiplier_bit_i;
            if (por_evt)
            begin
                timer_next = TW'(RESET_DELAY_CYCLES);
                bus_ready_next = 1'b0;
            end
        end
        else
        begin
            if (wr_commit)
            begin
                code_next = wr_code;
                pd_next = wr_pd;
            end
            if (sup_s && timer_done && !bus_ready_reg)
                bus_ready_next = 1'b1;
        end
    end

    // Set wins over a coincident clear
    assign por_flag_next = por_evt | (por_flag_reg & ~por_flag_clr_i);

    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sup_d_reg <= 1'b0;
            code_reg <= '0;
            pd_reg <= PD_LOAD_640K;
            vref_reg <= VREF_SUPPLY;
            gain_reg <= 1'b0;
            por_flag_reg <= 1'b0;
            timer_reg <= '0;
            bus_ready_reg <= 1'b0;
        end
        else
        begin
            sup_d_reg <= sup_s;
            code_reg <= code_next;
            pd_reg <= pd_next;
            vref_reg <= vref_next;
            gain_reg <= gain_next;
            por_flag_reg <= por_flag_next;
            timer_reg <= timer_next;
            bus_ready_reg <= bus_ready_next;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            wr_byte1_reg <= 8'h00;
        else if (evt.byte_done && evt.byte_idx == IDX_FIRST)
            wr_byte1_reg <= evt.byte_data;
    end

    // Analog controls come only from the volatile state
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            amp_en_reg <= 1'b0;
            load_reg <= PD_LOAD_640K;
            ref_conn_reg <= 1'b0;
            ref_buf_reg <= 1'b0;
            gain2_reg <= 1'b0;
        end
        else
        begin
            amp_en_reg <= powered;
            load_reg <= pd_reg;
            ref_conn_reg <= powered & pin_ref;
            ref_buf_reg <= powered & (vref_reg == VREF_PIN_BUF);
            gain2_reg <= pin_ref & gain_reg;
        end
    end

    // Pad only ever pulls low; high is left to the external pull-up
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sda_low_reg <= 1'b0;
            sda_oe_n_reg <= 1'b1;
        end
        else
        begin
            sda_low_reg <= 1'b0;
            sda_oe_n_reg <= ~evt.drive_low;
        end
    end

    assign sda_o = sda_low_reg;
    assign sda_oe_n_o = sda_oe_n_reg;
    assign por_flag_o = por_flag_reg;
    assign bus_ready_o = bus_ready_reg;
    assign ladder_code_o = code_reg;
    assign power_down_select_o = pd_reg;
    assign reference_source_select_o = vref_reg;
    assign output_multiplier_bit_o = gain_reg;
    assign amp_enable_o = amp_en_reg;
    assign pulldown_load_o = load_reg;
    assign ref_pin_connect_o = ref_conn_reg;
    assign ref_buffer_en_o = ref_buf_reg;
    assign gain_two_o = gain2_reg;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);

    chk_por_code_load: assert property (por_evt |=> code_reg == $past(nv_code_i))
        else $error("stored code not recalled on supply rise");
    chk_por_cfg_load: assert property (por_evt |=> pd_reg == $past(nv_power_down_select_i)
        && vref_reg == $past(nv_reference_source_select_i) && gain_reg == $past(nv_output_multiplier_bit_i))
        else $error("stored configuration not recalled on supply rise");
    chk_por_flag_set: assert property (por_evt |=> por_flag_o [*2])
        else $error("reset flag not set and held after supply rise");
    chk_port_held_shut: assert property (por_evt |=> !bus_ready_o [*8])
        else $error("serial port opened before reset delay");
    chk_port_opens: assert property (sup_s && !bor_evt && timer_reg == TW'(1) && !bus_ready_reg
        |-> ##2 bus_ready_o)
        else $error("serial port not opened when reset delay ended");
    chk_amp_follows_pd: assert property (##1 amp_enable_o == $past(pd_reg == PD_NORMAL))
        else $error("amplifier enable does not follow power-down select");
    chk_bor_pd_clamp: assert property (bor_evt |=> power_down_select_o == PD_LOAD_640K
        ##1 !amp_enable_o && pulldown_load_o == PD_LOAD_640K)
        else $error("brown-out did not force deepest power-down");
    chk_bor_clears: assert property (bor_evt |=> ladder_code_o == '0
        && reference_source_select_o == VREF_SUPPLY && !output_multiplier_bit_o)
        else $error("brown-out did not clear code, reference and gain");
    chk_sda_never_high: assert property (sda_o == 1'b0)
        else $error("data pad driven high");
    chk_supply_unity: assert property (!pin_ref |=> !gain_two_o)
        else $error("gain two while supply is the reference");
    chk_write_latch: assert property (wr_commit && !bor_evt && !por_evt |=> ladder_code_o == $past(wr_code))
        else $error("written code not latched at final acknowledge");
    chk_gcall_reload: assert property (gcall_reload && !bor_evt |=> ladder_code_o == $past(nv_code_i))
        else $error("general call reset did not recall stored code");
    chk_flag_clears: assert property (por_flag_clr_i && !por_evt |=> !por_flag_o)
        else $error("reset flag not cleared");
    chk_timer_reload: assert property (por_evt |=> timer_reg == TW'(RESET_DELAY_CYCLES))
        else $error("reset delay timer not started on supply rise");
    chk_bor_port_shut: assert property (bor_evt |=> !bus_ready_o)
        else $error("serial port left open after brown-out");
    chk_closed_no_ack: assert property (!bus_ready_reg |=> !evt.drive_low)
        else $error("acknowledge driven while serial port closed");

    // Analog controls lag the volatile state by one cycle
    chk_load_follows: assert property (##1 pulldown_load_o == $past(pd_reg))
        else $error("pull-down load does not follow power-down select");
    chk_ref_pin_off: assert property (!pin_ref |=> !ref_pin_connect_o)
        else $error("reference pin connected while supply is the reference");
    chk_buffer_path: assert property (##1 ref_buffer_en_o
        == $past(powered && vref_reg == VREF_PIN_BUF))
        else $error("reference buffer enable does not follow the select");
    chk_gain_two: assert property (pin_ref |=> gain_two_o == $past(gain_reg))
        else $error("gain two does not follow the multiplier bit");
    chk_write_pd: assert property (wr_commit && !bor_evt && !por_evt
        |=> power_down_select_o == $past(wr_pd))
        else $error("written power-down select not latched");

    cov_power_up: cover property (por_evt ##[1:300] bus_ready_o);
    cov_brown_out: cover property (bor_evt);
    cov_code_write: cover property (wr_commit);
    cov_gcall: cover property (gcall_reload);
    cov_flag_clear: cover property (por_flag_o ##1 !por_flag_o);
endmodule

// >>> rtl/i2c_evt_if.sv
// Byte events from the serial receiver to the reset and recall core.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface i2c_evt_if;
    logic [7:0] byte_data;
    logic [1:0] byte_idx;
    logic byte_done;
    logic is_gcall;
    logic drive_low;

    modport rx
    (
        output byte_data,
        output byte_idx,
        output byte_done,
        output is_gcall,
        output drive_low
    );
    modport core
    (
        input byte_data,
        input byte_idx,
        input byte_done,
        input is_gcall,
        input drive_low
    );
endinterface

// >>> rtl/i2c_target_rx.sv
// Write-only serial target: framing, address match and acknowledge drive.
// Assumes synchronised scl and sda levels on the core clock.
`timescale 1ns/1ps
module i2c_target_rx #(
    parameter logic [6:0] DEV_ADDR = 7'h60
)
(
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic enable_i,
    i2c_evt_if.rx evt
);
    import dac_rst_pkg::*;

    typedef enum {RX_IDLE, RX_BITS, RX_ACK} rx_state_t;
    rx_state_t state_reg, state_next;
    logic scl_d_reg, sda_d_reg;
    logic [7:0] shift_reg, shift_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [1:0] idx_reg, idx_next, done_idx_reg, done_idx_next;
    logic gcall_reg, gcall_next, drive_reg, drive_next, done_reg, done_next;

    // Clock is only ever sampled, never driven
    wire scl_rise = scl_i & ~scl_d_reg;
    wire scl_fall = ~scl_i & scl_d_reg;
    wire start_c = scl_i & scl_d_reg & sda_d_reg & ~sda_i;
    wire stop_c = scl_i & scl_d_reg & ~sda_d_reg & sda_i;
    wire byte_full = (cnt_reg == BITS_PER_BYTE);
    wire addr_hit = (shift_reg[7:1] == DEV_ADDR) && !shift_reg[0];
    wire gcall_hit = (shift_reg == GCALL_ADDR);
    wire want_ack = (idx_reg == IDX_ADDR) ? (addr_hit | gcall_hit) : 1'b1;

    always_comb
    begin
        state_next = state_reg;
        shift_next = shift_reg;
        cnt_next = cnt_reg;
        idx_next = idx_reg;
        done_idx_next = done_idx_reg;
        gcall_next = gcall_reg;
        drive_next = drive_reg;
        done_next = 1'b0;
        if (!enable_i || stop_c)
        begin
            state_next = RX_IDLE;
            drive_next = 1'b0;
        end
        else if (start_c)
        begin
            state_next = RX_BITS;
            cnt_next = 4'h0;
            idx_next = IDX_ADDR;
            drive_next = 1'b0;
        end
        else
        begin
            case (state_reg)
                RX_BITS:
                begin
                    if (scl_rise && !byte_full)
                    begin
                        shift_next = {shift_reg[6:0], sda_i};
                        cnt_next = cnt_reg + 4'h1;
                    end
                    else if (scl_fall && byte_full)
                    begin
                        if (want_ack)
                        begin
                            state_next = RX_ACK;
                            drive_next = 1'b1;
                            if (idx_reg == IDX_ADDR)
                                gcall_next = gcall_hit;
                        end
                        else
                            state_next = RX_IDLE;
                    end
                end
                RX_ACK:
                begin
                    if (scl_fall)
                    begin
                        state_next = RX_BITS;
                        drive_next = 1'b0;
                        done_next = 1'b1;
                        done_idx_next = idx_reg;
                        cnt_next = 4'h0;
                        // Saturate at 3 so over-long frames stay past the last index
                        if (idx_reg != 2'h3)
                            idx_next = idx_reg + 2'h1;
                    end
                end
                default:
                begin
                    state_next = RX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_reg <= RX_IDLE;
            scl_d_reg <= 1'b0;
            sda_d_reg <= 1'b0;
            shift_reg <= 8'h00;
            cnt_reg <= 4'h0;
            idx_reg <= 2'h0;
            done_idx_reg <= 2'h0;
            gcall_reg <= 1'b0;
            drive_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            scl_d_reg <= scl_i;
            sda_d_reg <= sda_i;
            shift_reg <= shift_next;
            cnt_reg <= cnt_next;
            idx_reg <= idx_next;
            done_idx_reg <= done_idx_next;
            gcall_reg <= gcall_next;
            drive_reg <= drive_next;
            done_reg <= done_next;
        end
    end

    assign evt.byte_data = shift_reg;
    assign evt.byte_idx = done_idx_reg;
    assign evt.byte_done = done_reg;
    assign evt.is_gcall = gcall_reg;
    assign evt.drive_low = drive_reg;

    chk_ack_after_fall: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        $changed(drive_reg) |-> $past(scl_fall || start_c || stop_c || !enable_i))
        else $error("acknowledge drive changed without a falling clock");
endmodule

// >>> rtl/pin_sync.sv
// Two-stage synchroniser, one lane per asynchronous pin.
// Assumes inputs are plain levels; stage one feeds stage two only.
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 3
)
(
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    generate
        for (genvar g = 0; g < W; g++)
        begin : g_lane
            logic meta_reg;
            logic sync_reg;
            always_ff @(posedge mclk_i or negedge rstn_i)
            begin
                if (!rstn_i)
                begin
                    meta_reg <= 1'b0;
                    sync_reg <= 1'b0;
                end
                else
                begin
                    meta_reg <= async_i[g];
                    sync_reg <= meta_reg;
                end
            end
            assign sync_o[g] = sync_reg;
        end
    endgenerate
endmodule

// >>> test/dac_supply_reset_and_recall_bench.sv
// Bench for supply reset, recall, brown-out clamp and serial code write.
// Assumes the master model on the far side and a pull-up on the data wire.
`timescale 1ns/1ps
module dac_supply_reset_and_recall_bench;
    import dac_rst_pkg::*;
    // Short delay keeps the run brief
    localparam int CW = 10;
    localparam int DLY = 20;
    logic mclk_i = 1'h0;
    logic rstn_i = 1'h0;
    logic sup = 1'h0;
    logic clr = 1'h0;
    logic go = 1'h0;
    logic shrt = 1'h0;
    logic nv_g = 1'h0;
    logic [CW-1:0] nv_code = '0;
    logic [1:0] nv_pd = '0;
    logic [1:0] nv_vref = '0;
    logic [7:0] b0 = '0;
    logic [7:0] b1 = '0;
    logic [7:0] b2 = '0;
    logic scl, m_low, busy, sda_pin, sda_o, sda_oe_n, rdy, flag, g_o, amp, conn, buf_en, g2;
    logic [2:0] acks;
    logic [CW-1:0] code;
    logic [1:0] pd, vref, load;
    logic [31:0] rs = 32'h0000_c147;
    int err_count = 0;
    int checks = 0;

    always #2 mclk_i = ~mclk_i;
    // Wired-and with pull-up
    assign sda_pin = !m_low && (sda_oe_n || sda_o);

    dac_supply_reset_and_recall #(.CODE_W(CW), .RESET_DELAY_CYCLES(DLY)) u_dut
    (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .supply_ok_i(sup), .scl_i(scl), .sda_i(sda_pin),
        .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .nv_code_i(nv_code), .nv_power_down_select_i(nv_pd),
        .nv_reference_source_select_i(nv_vref), .nv_output_multiplier_bit_i(nv_g),
        .por_flag_clr_i(clr), .por_flag_o(flag), .bus_ready_o(rdy), .ladder_code_o(code),
        .power_down_select_o(pd), .reference_source_select_o(vref), .output_multiplier_bit_o(g_o),
        .amp_enable_o(amp), .pulldown_load_o(load), .ref_pin_connect_o(conn),
        .ref_buffer_en_o(buf_en), .gain_two_o(g2)
    );

    i2c_master_model u_master
    (
        .go_i(go), .short_i(shrt), .byte0_i(b0), .byte1_i(b1), .byte2_i(b2), .sda_i(sda_pin),
        .scl_o(scl), .sda_low_o(m_low), .busy_o(busy), .acks_o(acks)
    );

    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction

    function automatic logic [5:0] analog(input logic [1:0] p, input logic [1:0] v, input logic g);
        return {p == PD_NORMAL, p, p == PD_NORMAL && v[VREF_PIN_BIT], p == PD_NORMAL && v == VREF_PIN_BUF,
            v[VREF_PIN_BIT] && g};
    endfunction

    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    task automatic check_vol(input string n, input logic [CW-1:0] c, input logic [1:0] p, input logic [1:0] v,
        input logic g);
        check({n, " code"}, code, c);
        check({n, " cfg"}, {pd, vref, g_o}, {p, v, g});
        check({n, " analog"}, {amp, load, conn, buf_en, g2}, analog(p, v, g));
    endtask

    task automatic apply_nv(input logic [31:0] r, input logic [1:0] p, input logic [1:0] v);
        @(posedge mclk_i);
        nv_code <= r[CW-1:0];
        nv_g <= r[16];
        nv_pd <= p;
        nv_vref <= v;
    endtask

    task automatic supply(input logic s);
        @(posedge mclk_i);
        sup <= s;
        step(10);
    endtask

    task automatic frame(input logic [7:0] a, input logic [7:0] x, input logic [7:0] y, input logic s,
        input logic [2:0] ea, input string n);
        @(posedge mclk_i);
        b0 <= a;
        b1 <= x;
        b2 <= y;
        shrt <= s;
        go <= 1'h1;
        @(posedge mclk_i);
        go <= 1'h0;
        step(2);
        for (int k = 0; k < 4000 && busy; k++)
            @(posedge mclk_i);
        // A hung frame counts as a mismatch
        check({n, " done"}, busy, 1'h0);
        step(8);
        check(n, acks, ea);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Device may only move the data line while the clock is low
    always @(sda_oe_n)
    begin
        if (rstn_i === 1'h1)
            check("ack edge", {scl, sda_o}, 2'h0);
    end

    initial
    begin
        // About five times the expected run
        repeat (40_000) @(posedge mclk_i);
        err_count++;
        $display("watchdog expired");
        stop_test();
    end

    initial
    begin
        logic [31:0] r;
        logic [11:0] w;
        step(8);
        rstn_i <= 1'h1;
        step(2);
        check_vol("reset", '0, PD_LOAD_640K, VREF_SUPPLY, 1'h0);
        check("reset flag port", {flag, rdy}, 2'h0);
        $display("test reset done");
        for (int i = 0; i < 16; i++)
        begin
            // Clear first, so each rise has to set the flag again
            clr <= 1'h1;
            apply_nv(rnd(), i[1:0], i[3:2]);
            clr <= 1'h0;
            supply(1'h1);
            check_vol("recall", nv_code, nv_pd, nv_vref, nv_g);
            check("por flag", flag, 1'h1);
            // Opens one cycle after the timer runs out
            step(DLY - 7);
            check("port early", rdy, 1'h0);
            step(2);
            check("port open", rdy, 1'h1);
            r = rnd();
            w = r[11:0];
            frame({DEF_DEV_ADDR, 1'h0}, {2'h0, r[13:12], w[11:8]}, w[7:0], 1'h0, 3'h7, "write ack");
            check_vol("write", w[11 -: CW], r[13:12], nv_vref, nv_g);
            supply(1'h0);
            check_vol("brownout", '0, PD_LOAD_640K, VREF_SUPPLY, 1'h0);
            check("brownout port", rdy, 1'h0);
        end
        $display("test recall write brownout done");
        frame({DEF_DEV_ADDR, 1'h0}, 8'h3f, 8'hff, 1'h0, 3'h0, "closed ack");
        check_vol("closed", '0, PD_LOAD_640K, VREF_SUPPLY, 1'h0);
        $display("test closed port done");
        r = rnd();
        apply_nv(r, PD_LOAD_1K, VREF_PIN_UNBUF);
        supply(1'h1);
        step(20);
        frame({DEF_DEV_ADDR ^ 7'h01, 1'h0}, 8'h0f, 8'hff, 1'h0, 3'h0, "wrong addr ack");
        check_vol("wrong addr", r[CW-1:0], PD_LOAD_1K, VREF_PIN_UNBUF, r[16]);
        $display("test wrong address done");
        r = rnd();
        apply_nv(r, PD_NORMAL, VREF_PIN_BUF);
        clr <= 1'h1;
        step(1);
        clr <= 1'h0;
        frame(GCALL_ADDR, GCALL_RESET_CMD, 8'h00, 1'h1, 3'h3, "gcall ack");
        check_vol("gcall", r[CW-1:0], PD_NORMAL, VREF_PIN_BUF, r[16]);
        check("gcall flag", flag, 1'h0);
        $display("test general call done");
        stop_test();
    end
endmodule

// >>> test/i2c_master_model.sv
// Serial master model: frames of two or three bytes with start and stop.
// Assumes the bench resolves the pulled-up data wire and feeds it back on sda_i.
`timescale 1ns/1ps
module i2c_master_model
(
    input wire logic go_i,
    input wire logic short_i,
    input wire logic [7:0] byte0_i,
    input wire logic [7:0] byte1_i,
    input wire logic [7:0] byte2_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o,
    output logic busy_o,
    output logic [2:0] acks_o
);
    // Quarter of the 48 ns link period
    localparam int Q = 12;

    // Data moves mid low phase, far from either clock edge
    task automatic put_bit(input logic b, output logic s);
        sda_low_o = !b;
        #Q;
        scl_o = 1'h1;
        #Q;
        s = sda_i;
        #Q;
        scl_o = 1'h0;
        #Q;
    endtask

    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            put_bit(d[i], s);
        put_bit(1'h1, s);
        ack = !s;
    endtask

    // Clock stands high between frames
    initial
    begin
        scl_o = 1'h1;
        sda_low_o = 1'h0;
        busy_o = 1'h0;
        acks_o = 3'h0;
        forever
        begin
            @(posedge go_i);
            // Keep pin edges off the core clock edges
            #1;
            busy_o = 1'h1;
            acks_o = 3'h0;
            sda_low_o = 1'h1;
            #(2 * Q);
            scl_o = 1'h0;
            #Q;
            put_byte(byte0_i, acks_o[0]);
            put_byte(byte1_i, acks_o[1]);
            if (!short_i)
                put_byte(byte2_i, acks_o[2]);
            sda_low_o = 1'h1;
            #Q;
            scl_o = 1'h1;
            #(2 * Q);
            sda_low_o = 1'h0;
            #(2 * Q);
            busy_o = 1'h0;
        end
    end
endmodule
